// *** fcr_bus_cycle.sv ***
/*
 * holds the shared package of the flash command controller and the
 * single bus-cycle engine that drives one read or write cycle on the
 * flash pins.
 * assumes one 40 MHz clock, an asynchronous active-low reset, and flash
 * inputs that are already synchronous to that clock.
 */

package fcr_pkg;
   // ==========================================================
   // widths and timing
   localparam int ADDR_W     = 22;
   localparam int DATA_W     = 16;
   localparam int CLK_MHZ    = 40;
   localparam int T_WP_NS    = 35;   // write strobe low, least
   localparam int T_WPH_NS   = 30;   // strobe high / data hold, least
   localparam int T_ACC_NS   = 90;   // read access, least wait
   localparam logic [3:0] WP_CYC  = 4'((T_WP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] WPH_CYC = 4'((T_WPH_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] ACC_CYC = 4'((T_ACC_NS * CLK_MHZ + 999) / 1000);

   // ==========================================================
   // command codes and unlock addresses (word / byte addressing)
   localparam logic [7:0] CMD_RESET   = 8'h00_F0;
   localparam logic [7:0] CMD_UNLOCK1 = 8'h00_AA;
   localparam logic [7:0] CMD_UNLOCK2 = 8'h00_55;
   localparam logic [7:0] CMD_AUTOSEL = 8'h00_90;
   localparam logic [7:0] CMD_QUERY   = 8'h00_98;
   localparam logic [7:0] CMD_SUSPEND = 8'h00_B0;
   localparam logic [7:0] CMD_RESUME  = 8'h00_30;
   localparam logic [ADDR_W-1:0] UNL1_W  = 22'h00_0555;
   localparam logic [ADDR_W-1:0] UNL1_B  = 22'h00_0AAA;
   localparam logic [ADDR_W-1:0] UNL2_W  = 22'h00_02AA;
   localparam logic [ADDR_W-1:0] UNL2_B  = 22'h00_0555;
   localparam logic [ADDR_W-1:0] QRY_W   = 22'h00_0055;
   localparam logic [ADDR_W-1:0] QRY_B   = 22'h00_00AA;
   localparam int TIMEOUT_BIT = 5;

   // ==========================================================
   // extended query table, word addresses base .. base+15
   localparam logic [ADDR_W-1:0] XQ_BASE_W = 22'h00_0040;
   localparam logic [ADDR_W-1:0] XQ_BASE_B = 22'h00_0080;
   localparam logic [4:0]        XQ_COUNT  = 5'h10;
   localparam logic [7:0] BOOT_BOTTOM = 8'h00_02;
   localparam logic [7:0] BOOT_TOP    = 8'h00_03;
   localparam logic [14:0][7:0] XQ_EXPECT = {
      8'h00_C5, 8'h00_B5,                     // accel_supply max / min, volt:tenth
      8'h00_00, 8'h00_00, 8'h00_00,           // page, burst, simultaneous
      8'h00_04, 8'h00_01,                     // protect scheme, temp unprotect
      8'h00_04, 8'h00_02, 8'h00_00,           // group size, suspend r/w, unlock+rev
      8'h00_31, 8'h00_31,                     // minor, major version
      8'h00_49, 8'h00_52, 8'h00_50};          // "PRI"

   // ==========================================================
   // types
   typedef enum logic [2:0] {
      OP_READ, OP_WRITE, OP_RESET, OP_AUTOSEL, OP_STATUS, OP_QUERY
   } fcr_op_t;
   typedef enum logic [2:0] {
      MODE_READ, MODE_ESR, MODE_AUTO, MODE_SEQ, MODE_EMBED
   } fcr_mode_t;
   typedef struct packed {
      fcr_op_t            op;
      logic [ADDR_W-1:0]  addr;
      logic [DATA_W-1:0]  data;
   } fcr_req_t;
   typedef struct packed {
      logic               wr;
      logic [ADDR_W-1:0]  addr;
      logic [DATA_W-1:0]  data;
      logic               last;
   } fcr_cyc_t;
   typedef struct packed {
      logic               ce_n;
      logic               we_n;
      logic               oe_n;
      logic [ADDR_W-1:0]  addr;
      logic [DATA_W-1:0]  dq;
      logic               dq_oe_n;
   } fcr_pins_t;
endpackage

module fcr_bus_cycle (
   // clock and reset
   input  wire logic                        sys_clk_in,
   input  wire logic                        rst_n_in,
   // cycle request
   input  wire logic                        start_in,
   input  wire fcr_pkg::fcr_cyc_t           cyc_in,
   output logic                             done_out,
   output logic [fcr_pkg::DATA_W-1:0]       rdata_out,
   // flash pins
   input  wire logic [fcr_pkg::DATA_W-1:0]  dq_in,
   output fcr_pkg::fcr_pins_t               pins_out
);
   typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_ACTIVE, BC_RECOVER} fcr_bc_t;

   fcr_bc_t                       st_reg, st_next;
   logic [3:0]                    cnt_reg, cnt_next;
   logic                          wr_reg, wr_next;
   logic                          done_reg, done_next;
   logic [fcr_pkg::DATA_W-1:0]    rd_reg, rd_next;
   fcr_pkg::fcr_pins_t            pin_reg, pin_next;

   localparam fcr_pkg::fcr_pins_t PINS_IDLE = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
      addr: '0, dq: '0, dq_oe_n: 1'b1};

   // ==========================================================
   // cycle sequencing: chip select first, then write strobe, so the
   // strobe edge is the later falling one; strobe and chip select rise on the same clock edge
   always_comb begin
      st_next   = st_reg;
      cnt_next  = cnt_reg;
      wr_next   = wr_reg;
      done_next = 1'b0;
      rd_next   = rd_reg;
      pin_next  = pin_reg;
      case (st_reg)
         BC_IDLE: begin
            if (start_in) begin
               wr_next          = cyc_in.wr;
               pin_next.ce_n    = 1'b0;
               pin_next.addr    = cyc_in.addr;
               pin_next.dq      = cyc_in.data;
               pin_next.dq_oe_n = ~cyc_in.wr;
               st_next          = BC_SETUP;
            end
         end
         BC_SETUP: begin
            pin_next.we_n = ~wr_reg;
            pin_next.oe_n = wr_reg;
            cnt_next      = wr_reg ? fcr_pkg::WP_CYC : fcr_pkg::ACC_CYC;
            st_next       = BC_ACTIVE;
         end
         BC_ACTIVE: begin
            cnt_next = cnt_reg - 4'h1;
            if (cnt_reg == 4'h1) begin
               if (!wr_reg) begin
                  rd_next = dq_in;
               end
               pin_next.we_n = 1'b1;
               pin_next.oe_n = 1'b1;
               pin_next.ce_n = 1'b1;
               cnt_next      = fcr_pkg::WPH_CYC;
               st_next       = BC_RECOVER;
            end
         end
         default: begin
            cnt_next = cnt_reg - 4'h1;
            if (cnt_reg == 4'h1) begin
               pin_next.dq_oe_n = 1'b1;
               done_next        = 1'b1;
               st_next          = BC_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_reg   <= BC_IDLE;
         cnt_reg  <= 4'h0;
         wr_reg   <= 1'b0;
         done_reg <= 1'b0;
         rd_reg   <= '0;
         pin_reg  <= PINS_IDLE;
      end else begin
         st_reg   <= st_next;
         cnt_reg  <= cnt_next;
         wr_reg   <= wr_next;
         done_reg <= done_next;
         rd_reg   <= rd_next;
         pin_reg  <= pin_next;
      end
   end

   assign done_out  = done_reg;
   assign rdata_out = rd_reg;
   assign pins_out  = pin_reg;

   AST_STROBE_EXCL: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      !(!pin_reg.we_n && !pin_reg.oe_n)) else $error("write and read strobes both low");
   AST_DATA_HOLD: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      $rose(pin_reg.we_n) |-> !pin_reg.dq_oe_n && $stable(pin_reg.dq))
      else $error("write data not held across strobe rise");
endmodule // fcr_bus_cycle

// *** fcr_flash_host.sv ***
/*
 * host-side command controller for a parallel NOR flash: issues reset,
 * autoselect entry, raw command cycles, status polls and an extended
 * query check, and tracks which mode the flash is in.
 * assumes the flash ready line and data pins are synchronous to the
 * 40 MHz clock; the testbench resolves the data wire from dq_oe_n.
 */
module fcr_flash_host #(
   parameter bit TOP_BOOT = 1'b0
) (
   // clock and reset
   input  wire logic                        sys_clk_in,
   input  wire logic                        rst_n_in,
   // user request port
   input  wire logic                        req_valid_in,
   input  wire fcr_pkg::fcr_req_t           req_in,
   input  wire logic                        byte_mode_in,
   output logic                             busy_out,
   output logic                             done_out,
   output logic                             refused_out,
   output logic [fcr_pkg::DATA_W-1:0]       rdata_out,
   // tracked state
   output fcr_pkg::fcr_mode_t               mode_out,
   output logic                             suspended_out,
   output logic                             timeout_out,
   output logic                             query_ok_out,
   // flash pins
   input  wire logic [fcr_pkg::DATA_W-1:0]  dq_in,
   input  wire logic                        ready_in,
   output fcr_pkg::fcr_pins_t               pins_out,
   output logic                             byte_n_out
);
   typedef enum logic [1:0] {SQ_IDLE, SQ_ISSUE, SQ_WAIT} fcr_sq_t;

   fcr_sq_t                     sq_reg, sq_next;
   fcr_pkg::fcr_req_t           rq_reg, rq_next;
   logic [4:0]                  idx_reg, idx_next;
   fcr_pkg::fcr_mode_t          mode_reg, mode_next;
   logic                        susp_reg, susp_next;
   logic                        tmo_reg, tmo_next;
   logic                        qok_reg, qok_next;
   logic                        busy_reg, busy_next;
   logic                        done_reg, done_next;
   logic                        ref_reg, ref_next;
   logic                        byte_reg, byte_next;
   logic [fcr_pkg::DATA_W-1:0]  rd_reg, rd_next;
   logic                        start;
   logic                        bc_done;
   logic [fcr_pkg::DATA_W-1:0]  bc_rdata;
   fcr_pkg::fcr_cyc_t           cyc;

   // ==========================================================
   // expected extended-query byte for entry i
   function automatic logic [7:0] xq_expect(input logic [3:0] i);
      if (i == 4'hF) begin
         xq_expect = TOP_BOOT ? fcr_pkg::BOOT_TOP : fcr_pkg::BOOT_BOTTOM;
      end else begin
         xq_expect = fcr_pkg::XQ_EXPECT[i];
      end
   endfunction

   function automatic logic [fcr_pkg::ADDR_W-1:0] unl(input logic b, input logic second);
      if (second) begin
         unl = b ? fcr_pkg::UNL2_B : fcr_pkg::UNL2_W;
      end else begin
         unl = b ? fcr_pkg::UNL1_B : fcr_pkg::UNL1_W;
      end
   endfunction

   // ==========================================================
   // cycle i of the current operation
   function automatic fcr_pkg::fcr_cyc_t seq_cycle(input fcr_pkg::fcr_req_t r,
                                                   input logic [4:0] i, input logic b);
      fcr_pkg::fcr_cyc_t c;
      c = '{wr: 1'b1, addr: r.addr, data: r.data, last: 1'b1};
      case (r.op)
         fcr_pkg::OP_READ, fcr_pkg::OP_STATUS: begin
            c.wr = 1'b0;
         end
         fcr_pkg::OP_RESET: begin
            c.data = {8'h00, fcr_pkg::CMD_RESET};
         end
         fcr_pkg::OP_AUTOSEL: begin
            c.last = (i == 5'd2);
            c.addr = unl(b, i == 5'd1);
            c.data = {8'h00, (i == 5'd0) ? fcr_pkg::CMD_UNLOCK1 :
                      (i == 5'd1) ? fcr_pkg::CMD_UNLOCK2 : fcr_pkg::CMD_AUTOSEL};
         end
         fcr_pkg::OP_QUERY: begin
            c.last = (i == fcr_pkg::XQ_COUNT + 5'd1);
            if (i == 5'd0) begin
               c.addr = b ? fcr_pkg::QRY_B : fcr_pkg::QRY_W;
               c.data = {8'h00, fcr_pkg::CMD_QUERY};
            end else if (c.last) begin
               c.data = {8'h00, fcr_pkg::CMD_RESET};
            end else begin
               c.wr   = 1'b0;
               c.addr = b ? fcr_pkg::XQ_BASE_B + {i - 5'd1, 1'b0}
                          : fcr_pkg::XQ_BASE_W + (i - 5'd1);
            end
         end
         default: begin
         end
      endcase
      return c;
   endfunction

   assign cyc   = seq_cycle(rq_reg, idx_reg, byte_reg);
   assign start = (sq_reg == SQ_ISSUE);

   fcr_bus_cycle u_bus (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .start_in   (start),
      .cyc_in     (cyc),
      .done_out   (bc_done),
      .rdata_out  (bc_rdata),
      .dq_in      (dq_in),
      .pins_out   (pins_out)
   );

   // ==========================================================
   // request acceptance, sequencing and mode tracking
   always_comb begin
      sq_next   = sq_reg;
      rq_next   = rq_reg;
      idx_next  = idx_reg;
      mode_next = mode_reg;
      susp_next = susp_reg;
      tmo_next  = tmo_reg;
      qok_next  = qok_reg;
      busy_next = busy_reg;
      done_next = 1'b0;
      ref_next  = 1'b0;
      byte_next = byte_reg;
      rd_next   = rd_reg;
      if (mode_reg == fcr_pkg::MODE_EMBED && ready_in) begin
         mode_next = susp_reg ? fcr_pkg::MODE_ESR : fcr_pkg::MODE_READ;
      end
      case (sq_reg)
         SQ_IDLE: begin
            if (req_valid_in) begin
               if ((req_in.op == fcr_pkg::OP_RESET && !ready_in && !tmo_reg) ||
                   (req_in.op == fcr_pkg::OP_AUTOSEL &&
                    (!ready_in || (mode_reg != fcr_pkg::MODE_READ &&
                                   mode_reg != fcr_pkg::MODE_ESR)))) begin
                  ref_next = 1'b1;
               end else begin
                  rq_next   = req_in;
                  idx_next  = 5'd0;
                  byte_next = byte_mode_in;
                  busy_next = 1'b1;
                  qok_next  = (req_in.op == fcr_pkg::OP_QUERY) ? 1'b1 : qok_reg;
                  sq_next   = SQ_ISSUE;
               end
            end
         end
         SQ_ISSUE: begin
            sq_next = SQ_WAIT;
         end
         default: begin
            if (bc_done) begin
               if (!cyc.wr) begin
                  rd_next = bc_rdata;
               end
               if (rq_reg.op == fcr_pkg::OP_QUERY && !cyc.wr &&
                   bc_rdata[7:0] != xq_expect(4'(idx_reg - 5'd1))) begin
                  qok_next = 1'b0;
               end
               if (cyc.last) begin
                  sq_next   = SQ_IDLE;
                  busy_next = 1'b0;
                  done_next = 1'b1;
                  case (rq_reg.op)
                     fcr_pkg::OP_RESET, fcr_pkg::OP_QUERY: begin
                        mode_next = susp_reg ? fcr_pkg::MODE_ESR
                                             : fcr_pkg::MODE_READ;
                        tmo_next  = 1'b0;
                     end
                     fcr_pkg::OP_AUTOSEL: begin
                        mode_next = fcr_pkg::MODE_AUTO;
                     end
                     fcr_pkg::OP_WRITE: begin
                        if (rq_reg.data[7:0] == fcr_pkg::CMD_SUSPEND) begin
                           susp_next = 1'b1;
                           mode_next = fcr_pkg::MODE_ESR;
                        end else if (rq_reg.data[7:0] == fcr_pkg::CMD_RESUME) begin
                           susp_next = 1'b0;
                           mode_next = fcr_pkg::MODE_EMBED;
                        end else if (mode_reg != fcr_pkg::MODE_AUTO) begin
                           mode_next = fcr_pkg::MODE_SEQ;
                        end
                     end
                     fcr_pkg::OP_STATUS: begin
                        if (!ready_in) begin
                           mode_next = fcr_pkg::MODE_EMBED;
                        end
                        if (!ready_in && bc_rdata[fcr_pkg::TIMEOUT_BIT]) begin
                           tmo_next      = 1'b1;
                           rq_next.op    = fcr_pkg::OP_RESET;
                           busy_next     = 1'b1;
                           done_next     = 1'b0;
                           sq_next       = SQ_ISSUE;
                        end
                     end
                     default: begin
                     end
                  endcase
               end else begin
                  idx_next = idx_reg + 5'd1;
                  sq_next  = SQ_ISSUE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sq_reg   <= SQ_IDLE;
         rq_reg   <= '0;
         idx_reg  <= 5'd0;
         mode_reg <= fcr_pkg::MODE_READ;
         susp_reg <= 1'b0;
         tmo_reg  <= 1'b0;
         qok_reg  <= 1'b0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         ref_reg  <= 1'b0;
         byte_reg <= 1'b0;
         rd_reg   <= '0;
      end else begin
         sq_reg   <= sq_next;
         rq_reg   <= rq_next;
         idx_reg  <= idx_next;
         mode_reg <= mode_next;
         susp_reg <= susp_next;
         tmo_reg  <= tmo_next;
         qok_reg  <= qok_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
         ref_reg  <= ref_next;
         byte_reg <= byte_next;
         rd_reg   <= rd_next;
      end
   end

   assign busy_out      = busy_reg;
   assign done_out      = done_reg;
   assign refused_out   = ref_reg;
   assign rdata_out     = rd_reg;
   assign mode_out      = mode_reg;
   assign suspended_out = susp_reg;
   assign timeout_out   = tmo_reg;
   assign query_ok_out  = qok_reg;
   assign byte_n_out    = ~byte_reg;

   // ==========================================================
   // checks
   AST_RESET_REFUSED: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      sq_reg == SQ_IDLE && req_valid_in && req_in.op == fcr_pkg::OP_RESET && !ready_in
      && !tmo_reg |=> ref_reg && sq_reg == SQ_IDLE) else $error("reset taken while busy");
   AST_AUTOSEL_REFUSED: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      sq_reg == SQ_IDLE && req_valid_in && req_in.op == fcr_pkg::OP_AUTOSEL
      && mode_reg == fcr_pkg::MODE_SEQ |=> ref_reg) else $error("autoselect from bad mode");
   AST_RESET_MODE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      done_reg && rq_reg.op == fcr_pkg::OP_RESET |->
      mode_reg == (susp_reg ? fcr_pkg::MODE_ESR : fcr_pkg::MODE_READ))
      else $error("reset left wrong mode");
   AST_AUTO_HOLD: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      mode_reg == fcr_pkg::MODE_AUTO && !$rose(done_reg) ##1 !done_reg
      |-> mode_reg == fcr_pkg::MODE_AUTO) else $error("autoselect left without reset");
   AST_AUTOSEL_CYCLES: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      $rose(mode_reg == fcr_pkg::MODE_AUTO) |-> $past(rq_reg.op) == fcr_pkg::OP_AUTOSEL
      && $past(idx_reg) == 5'd2) else $error("autoselect entered early");
   AST_SUSPEND_SET: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      $rose(susp_reg) |-> mode_reg == fcr_pkg::MODE_ESR && rq_reg.op == fcr_pkg::OP_WRITE)
      else $error("suspend flag without suspend mode");
   AST_TIMEOUT_RESET: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      $rose(tmo_reg) |-> ##[1:12] (!pins_out.we_n && pins_out.dq[7:0] == fcr_pkg::CMD_RESET))
      else $error("no reset write after timeout");
   AST_QUERY_ADDR: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      start && rq_reg.op == fcr_pkg::OP_QUERY && !cyc.wr && !byte_reg |->
      cyc.addr == fcr_pkg::XQ_BASE_W + (idx_reg - 5'd1)) else $error("query address wrong");
endmodule // fcr_flash_host

// *** fcr_flash_model.sv ***
/* behavioural flash device for the command controller bench.
   assumes registered host pins; the bench resolves the shared data wire. */
module fcr_flash_model #(
   parameter logic [15:0] MFR_ID = 16'h00_3C,  // arbitrary value
   parameter logic [15:0] DEV_ID = 16'h22_A7   // arbitrary value
) (
   // host pins and the bench's failure switch
   input  wire fcr_pkg::fcr_pins_t pins_in,
   input  wire logic               byte_n_in,
   input  wire logic               fail_in,
   // answers
   output logic [15:0]             dq_out,
   output logic                    ready_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ======================================================
   // state
   localparam logic [7:0] TBL [16] = '{8'h50, 8'h52, 8'h49, 8'h31, 8'h31, 8'h00, 8'h02, 8'h04,
      8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'hB5, 8'hC5, 8'h02};
   logic [21:0] wa, la;
   logic [7:0]  d;
   logic [1:0]  seq = 2'd0, st = 2'd0;  // st: 0 array, 1 identifier, 2 query
   logic        busy = 1'b0, susp = 1'b0, act = 1'b0;
   logic [15:0] v, last = 16'h0000;
   assign wa = byte_n_in ? pins_in.addr : pins_in.addr >> 1;
   assign d = pins_in.dq[7:0];
   // ======================================================
   // command writes: address on the later fall, data on the earlier rise
   always @(negedge pins_in.we_n or negedge pins_in.ce_n) if (!pins_in.we_n && !pins_in.ce_n) begin
      la = wa;
      act = 1'b1;
   end
   always @(posedge pins_in.we_n or posedge pins_in.ce_n) if (act) begin
      act = 1'b0;
      if (busy) busy = !(fail_in && d == 8'hF0);
      else if (d == 8'hF0) {st, seq} = 4'h0;
      else if (seq == 2'd0 && la == 22'h00_0555 && d == 8'hAA) seq = 2'd1;
      else if (seq == 2'd1 && la == 22'h00_02AA && d == 8'h55) seq = 2'd2;
      else if (seq == 2'd2 && d == 8'h90) {st, seq} = 4'h4;
      else if (la == 22'h00_0055 && d == 8'h98) st = 2'd2;
      else if (d == 8'hB0) susp = 1'b1;
      else if (d == 8'h30) {susp, busy} = 2'b01;
   end
   // a stuck operation only ends by a reset write; the wait is polled so
   // a reset that ends it early never lets a stale timer cut the next one
   always @(posedge busy) begin
      for (int t = 0; t < 1000 && busy; t++) #1;
      if (busy && !fail_in) busy = 1'b0;
   end
   // ======================================================
   // read data; released wire shows the inverse so stale values never match
   always_comb begin
      if (busy) v = {10'h000, fail_in, 5'h00};
      else if (st == 2'd2) v = (wa[21:4] == 18'h0_0004) ? {8'h00, TBL[wa[3:0]]} : 16'h0000;
      else if (st == 2'd1) v = wa[7:0] == 8'h00 ? MFR_ID : wa[7:0] == 8'h01 ? DEV_ID : 16'h0000;
      else v = wa[15:0] ^ 16'h5A5A;
   end
   always @(posedge pins_in.oe_n) last = v;
   assign dq_out = (!pins_in.ce_n && !pins_in.oe_n) ? v : ~last;
   assign ready_out = !busy;
endmodule // fcr_flash_model

// *** testbench.sv ***
/* self-checking bench: controller against the flash device model.
   assumes the controller package and modules are compiled first. */
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
   $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] MFR = 16'h00_3C;  // arbitrary value
   localparam logic [15:0] DEV = 16'h22_A7;  // arbitrary value
   logic               sys_clk_in = 1'b0, rst_n_in = 1'b0, req_valid_in = 1'b0;
   logic               byte_mode_in = 1'b0, fail = 1'b0, got_ref;
   fcr_pkg::fcr_req_t  req_in = '0;
   fcr_pkg::fcr_mode_t mode_out;
   fcr_pkg::fcr_pins_t pins_out;
   logic [15:0]        rdata_out, dq_in, mdl_dq;
   logic               busy_out, done_out, refused_out, suspended_out, timeout_out;
   logic               query_ok_out, ready_in, byte_n_out;
   int                 errors = 0, check_count = 0;
   logic [21:0]        aa [4] = '{22'h00_0000, 22'h00_0001, 22'h00_0001, 22'h01_0002};
   logic [15:0]        ee [4] = '{MFR, DEV, DEV, 16'h0000};
   assign dq_in = pins_out.dq_oe_n ? mdl_dq : pins_out.dq;
   initial forever #12.5 sys_clk_in = ~sys_clk_in;
   fcr_flash_host uut (.sys_clk_in, .rst_n_in, .req_valid_in, .req_in, .byte_mode_in,
      .busy_out, .done_out, .refused_out, .rdata_out, .mode_out, .suspended_out, .timeout_out,
      .query_ok_out, .dq_in, .ready_in, .pins_out, .byte_n_out);
   fcr_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV)) dev (.pins_in(pins_out), .byte_n_in(byte_n_out),
      .fail_in(fail), .dq_out(mdl_dq), .ready_out(ready_in));
   // ======================================================
   // access tasks
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic op(input fcr_pkg::fcr_op_t o, input logic [21:0] a, input logic [15:0] d = 0,
                     input logic bm = 1'b0);
      int n;
      n = 0;
      req_valid_in <= 1'b1;
      req_in <= '{o, a, d};
      byte_mode_in <= bm;
      @(posedge sys_clk_in);
      req_valid_in <= 1'b0;
      #1;
      `CHK(busy_out, ~refused_out)
      while (done_out !== 1'b1 && refused_out !== 1'b1 && n < 3000) begin
         @(posedge sys_clk_in);
         #1 n++;
      end
      got_ref = refused_out;
      if (n >= 3000) begin
         errors++;
         wrap_up();
      end
      @(posedge sys_clk_in);
   endtask
   task automatic wait_mode(input fcr_pkg::fcr_mode_t m);
      for (int n = 0; n < 300 && mode_out !== m; n++) @(posedge sys_clk_in);
      `CHK(mode_out, m)
      if (mode_out !== m) wrap_up();
   endtask
   // ======================================================
   // tests
   initial begin
      repeat (3) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      `CHK(mode_out, fcr_pkg::MODE_READ)
      op(fcr_pkg::OP_READ, 22'h00_1234);
      `CHK(rdata_out, 16'h1234 ^ 16'h5A5A)
      $display("power-up read test done");
      for (int b = 0; b < 2; b++) begin
         op(fcr_pkg::OP_QUERY, 22'h00_0000, 16'h0000, b[0]);
         `CHK(query_ok_out, 1'b1)
         `CHK(mode_out, fcr_pkg::MODE_READ)
      end
      $display("extended query test done");
      op(fcr_pkg::OP_AUTOSEL, 22'h00_0000);
      `CHK(mode_out, fcr_pkg::MODE_AUTO)
      for (int i = 0; i < 4; i++) begin
         op(fcr_pkg::OP_READ, aa[i]);
         `CHK(rdata_out, ee[i])
      end
      op(fcr_pkg::OP_RESET, 22'h3F_FFFF);
      `CHK(mode_out, fcr_pkg::MODE_READ)
      op(fcr_pkg::OP_READ, 22'h00_1234);
      `CHK(rdata_out, 16'h1234 ^ 16'h5A5A)
      $display("identifier test done");
      op(fcr_pkg::OP_WRITE, 22'h00_0555, 16'h00AA);
      `CHK(mode_out, fcr_pkg::MODE_SEQ)
      op(fcr_pkg::OP_AUTOSEL, 22'h00_0000);
      `CHK(got_ref, 1'b1)
      op(fcr_pkg::OP_RESET, 22'h00_0000);
      `CHK(mode_out, fcr_pkg::MODE_READ)
      $display("broken sequence test done");
      op(fcr_pkg::OP_WRITE, 22'h00_0000, 16'h00B0);
      `CHK(suspended_out, 1'b1)
      `CHK(mode_out, fcr_pkg::MODE_ESR)
      op(fcr_pkg::OP_AUTOSEL, 22'h00_0000);
      `CHK(mode_out, fcr_pkg::MODE_AUTO)
      op(fcr_pkg::OP_RESET, 22'h00_0000);
      `CHK(mode_out, fcr_pkg::MODE_ESR)
      $display("suspend test done");
      fail <= 1'b1;
      op(fcr_pkg::OP_WRITE, 22'h00_0000, 16'h0030);
      op(fcr_pkg::OP_RESET, 22'h00_1000);
      `CHK(got_ref, 1'b1)
      op(fcr_pkg::OP_AUTOSEL, 22'h00_0000);
      `CHK(got_ref, 1'b1)
      op(fcr_pkg::OP_STATUS, 22'h00_0000);
      `CHK(timeout_out, 1'b0)
      wait_mode(fcr_pkg::MODE_READ);
      `CHK(ready_in, 1'b1)
      $display("timeout test done");
      fail <= 1'b0;
      op(fcr_pkg::OP_WRITE, 22'h00_0000, 16'h0030);
      `CHK(mode_out, fcr_pkg::MODE_EMBED)
      wait_mode(fcr_pkg::MODE_READ);
      $display("completion test done");
      wrap_up();
   end
endmodule // testbench
